// ===== sarseq_pkg.sv
// Purpose: Shared constants and types for the successive-approximation converter sequencer.
// Assumes: One state time is a fixed number of 125 MHz clock cycles.
// Notes: All timing counts derive from the times named here.
package sarseq_pkg;
   // ***********************************
   // Timing
   // ***********************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int STATE_TIME_NS = 250;
   localparam int CONV_TIME_NS = 22000;
   localparam int STATE_CYC = STATE_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_STATES = 88;
   localparam int CONV_CYC = CONV_STATES * STATE_CYC;
   localparam int CONV_LIMIT_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int SW_START_STATES = 3;
   localparam int DELAY_STATES = 1;
   localparam int SAMPLE_STATES = 4;
   localparam int ZERO_STATES = 3;
   localparam int TRIAL_STATES = 8;
   localparam logic [4:0] TICK_LAST = 5'(STATE_CYC - 1);
   localparam logic [2:0] DELAY_LAST = 3'(DELAY_STATES - 1);
   localparam logic [2:0] SAMPLE_LAST = 3'(SAMPLE_STATES - 1);
   localparam logic [2:0] ZERO_LAST = 3'(ZERO_STATES - 1);
   localparam logic [2:0] TRIAL_LAST = 3'(TRIAL_STATES - 1);
   // ***********************************
   // Converter layout
   // ***********************************
   localparam int SAR_BITS = 10;
   localparam int CHANNELS = 8;
   localparam logic [3:0] HSO_START_CODE = 4'hF;
   localparam logic [9:0] SAR_RESET = 10'h000;
   localparam logic [9:0] SAR_FIRST = 10'h1FF;
   localparam logic [9:0] SAR_UNIT = 10'h001;
   localparam logic [3:0] MSB_INDEX = 4'h9;
   // ***********************************
   // Types
   // ***********************************
   typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_ZERO, ST_TRIAL} sarseq_state_t;
   typedef struct packed {
      logic valid;
      logic [3:0] code;
   } sarseq_hso_t;
   typedef struct packed {
      logic busy;
      logic done;
      logic [9:0] result;
   } sarseq_status_t;
endpackage

// ===== sarseq_sync2.sv
// Purpose: Two-stage synchroniser for one asynchronous level.
// Assumes: The input is a slow level such as the comparator decision.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module sarseq_sync2 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic asyncIn,
   output logic syncOut
);
   logic meta_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== sarseq_core.sv
// Purpose: Start control, sample timing and binary search of a ten-bit converter.
// Assumes: The comparator output is high when the held input is above the test level.
// Notes: A software start is ignored while a conversion runs; an HSO start command stays pending until a timer increment arrives while idle.
`timescale 1ns/10ps
`default_nettype none
module sarseq_core
   import sarseq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire sarseq_pkg::sarseq_hso_t hsoCmd,
   input wire logic timerInc,
   input wire logic swGo,
   input wire logic [2:0] channelSel,
   input wire logic compAbove,
   output logic [2:0] muxSel,
   output logic sampleOn,
   output logic autoZero,
   output logic [9:0] testLevel,
   output sarseq_pkg::sarseq_status_t status
);
   import sarseq_pkg::*;
   // ***********************************
   // State and wires
   // ***********************************
   sarseq_state_t st_q, st_d;
   logic [4:0] tick_q, tick_d;
   logic [2:0] ph_q, ph_d;
   logic [3:0] bit_q, bit_d;
   logic [9:0] sar_q, sar_d;
   logic [9:0] result_q, result_d;
   logic hsoPend_q, hsoPend_d;
   logic done_q, done_d;
   logic busy_q, sample_q, zero_q;
   logic [2:0] mux_q;
   logic compSync;
   wire logic isIdle = (st_q == ST_IDLE);
   wire logic hsoHit = hsoCmd.valid && (hsoCmd.code == HSO_START_CODE);
   wire logic hsoTake = isIdle && hsoPend_q && timerInc;
   wire logic swTake = isIdle && swGo;
   wire logic startReq = hsoTake || swTake;
   wire logic stTick = (tick_q == TICK_LAST);
   wire logic [2:0] phLim = (st_q == ST_DELAY) ? DELAY_LAST :
                            (st_q == ST_SAMPLE) ? SAMPLE_LAST :
                            (st_q == ST_ZERO) ? ZERO_LAST : TRIAL_LAST;
   wire logic phEnd = !isIdle && stTick && (ph_q == phLim);
   wire logic lastTrial = (bit_q == 4'h0);
   wire logic trialEnd = (st_q == ST_TRIAL) && phEnd;
   wire logic [9:0] bitMask = SAR_UNIT << bit_q;
   wire logic [9:0] lowMask = bitMask >> 1;
   wire logic [9:0] sarTrial = (sar_q & ~bitMask & ~lowMask) | (compSync ? bitMask : SAR_RESET);

   sarseq_sync2 u_compSync (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(compAbove),
      .syncOut(compSync)
   );

   // ***********************************
   // Sequence
   // ***********************************
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE: begin
            if (startReq) begin
               st_d = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (phEnd) begin
               st_d = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (phEnd) begin
               st_d = ST_ZERO;
            end
         end
         ST_ZERO: begin
            if (phEnd) begin
               st_d = ST_TRIAL;
            end
         end
         ST_TRIAL: begin
            if (phEnd && lastTrial) begin
               st_d = ST_IDLE;
            end
         end
      endcase
   end

   assign tick_d = (isIdle || stTick) ? 5'h00 : tick_q + 5'h01;
   assign ph_d = (isIdle || phEnd) ? 3'h0 : (stTick ? ph_q + 3'h1 : ph_q);
   assign bit_d = startReq ? MSB_INDEX : (trialEnd && !lastTrial ? bit_q - 4'h1 : bit_q);
   assign sar_d = startReq ? SAR_RESET :
                  ((st_q == ST_ZERO) && phEnd) ? SAR_FIRST :
                  trialEnd ? sarTrial : sar_q;
   assign result_d = (trialEnd && lastTrial) ? sarTrial : result_q;
   assign hsoPend_d = hsoHit || (hsoPend_q && !hsoTake);
   assign done_d = (trialEnd && lastTrial) || (done_q && !startReq);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         tick_q <= 5'h00;
         ph_q <= 3'h0;
         bit_q <= MSB_INDEX;
         sar_q <= SAR_RESET;
         result_q <= SAR_RESET;
         hsoPend_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tick_q <= tick_d;
         ph_q <= ph_d;
         bit_q <= bit_d;
         sar_q <= sar_d;
         result_q <= result_d;
         hsoPend_q <= hsoPend_d;
         done_q <= done_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         sample_q <= 1'b0;
         zero_q <= 1'b0;
         mux_q <= 3'h0;
      end else begin
         busy_q <= (st_d != ST_IDLE);
         sample_q <= (st_d == ST_SAMPLE);
         zero_q <= (st_d == ST_ZERO);
         mux_q <= startReq ? channelSel : mux_q;
      end
   end

   assign muxSel = mux_q;
   assign sampleOn = sample_q;
   assign autoZero = zero_q;
   assign testLevel = sar_q;
   assign status = '{busy: busy_q, done: done_q, result: result_q};

   // ***********************************
   // Checks
   // ***********************************
   localparam int SW_LIM = SW_START_STATES * STATE_CYC;
   logic [11:0] sampCnt_q, busyCnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sampCnt_q <= 12'h000;
         busyCnt_q <= 12'h000;
      end else begin
         sampCnt_q <= sample_q ? sampCnt_q + 12'h001 : 12'h000;
         busyCnt_q <= busy_q ? busyCnt_q + 12'h001 : 12'h000;
      end
   end

   a_start_any: assert property (@(posedge clk) disable iff (!rst_n)
      (isIdle && (swGo || (hsoPend_q && timerInc))) |=> (busy_q && !done_q))
      else $error("Start request not taken.");
   a_hso_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (isIdle && !swGo && !timerInc) |=> !busy_q)
      else $error("Conversion began without timer increment.");
   a_sw_start: assert property (@(posedge clk) disable iff (!rst_n)
      (isIdle && swGo) |-> ##[1:SW_LIM] busy_q)
      else $error("Software start late.");
   a_delay_reset: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == ST_DELAY) |-> (sar_q == SAR_RESET && !sample_q))
      else $error("Register not reset during delay.");
   a_sample_len: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(sample_q) |-> (sampCnt_q == 12'(SAMPLE_STATES * STATE_CYC) && zero_q))
      else $error("Sample window length wrong.");
   a_first_trial: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(zero_q) |-> (sar_q == SAR_FIRST && st_q == ST_TRIAL))
      else $error("First trial code wrong.");
   a_trial_bit: assert property (@(posedge clk) disable iff (!rst_n)
      (trialEnd && !lastTrial) |=> (sar_q[bit_q] == 1'b0 && sar_q[bit_q + 4'h1] == $past(compSync)))
      else $error("Trial update wrong.");
   a_conv_total: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(done_q) |-> (busyCnt_q == 12'(CONV_CYC) && busyCnt_q <= 12'(CONV_LIMIT_CYC)))
      else $error("Conversion length wrong.");
   a_mux_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (busy_q && !isIdle) |=> $stable(mux_q))
      else $error("Channel changed during conversion.");
   a_done_result: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(done_q) |-> (result_q == sar_q && !busy_q))
      else $error("Done without valid result.");

   c_hso_conv: cover property (@(posedge clk) disable iff (!rst_n) hsoTake ##[1:300] sample_q);
   c_sw_conv: cover property (@(posedge clk) disable iff (!rst_n) swTake ##1 busy_q);
   c_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(done_q));
   c_full: cover property (@(posedge clk) disable iff (!rst_n) $rose(done_q) && result_q == 10'h3FF);
endmodule
`default_nettype wire

// ===== sarseq_analog_model.sv
// Purpose: Analog sources, sample capacitor and comparator that face the sequencer.
// Assumes: Each channel level is an ideal ten-bit code.
// Notes: The comparator output is meaningless during auto-zero, so it toggles then.
`timescale 1ns/10ps
`default_nettype none
module sarseq_analog_model (
   input wire logic clk,
   input wire logic [7:0][9:0] chanLevel,
   input wire logic [2:0] muxSel,
   input wire logic sampleOn,
   input wire logic autoZero,
   input wire logic [9:0] testLevel,
   output logic compAbove
);
   logic [9:0] heldQ = 10'h000;
   logic junkQ = 1'b0;
   always @(posedge clk) begin
      if (sampleOn) begin
         heldQ <= chanLevel[muxSel];
      end
      junkQ <= ~junkQ;
   end
   assign compAbove = autoZero ? junkQ : (heldQ > testLevel);
endmodule
`default_nettype wire

// ===== sar_adc_sequencer_bench.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Expected codes equal the ideal levels fed to the analog model.
// Notes: The driver queues channel and code, the monitor checks the channel at busy and the code at done.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer_bench;
   import sarseq_pkg::*;
   localparam logic [3:0][9:0] EDGE_LEVELS = {10'h1FF, 10'h200, 10'h3FF, 10'h000};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   sarseq_hso_t hsoCmd = '0;
   logic timerInc = 1'b0;
   logic swGo = 1'b0;
   logic [2:0] channelSel = 3'h0;
   logic [7:0][9:0] chanLevel = '0;
   logic compAbove;
   logic [2:0] muxSel;
   logic sampleOn;
   logic autoZero;
   logic [9:0] testLevel;
   sarseq_status_t status;
   logic [12:0] expQ [$];
   logic [15:0] lfsrQ = 16'h0051;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   int busyAt = 0;
   int sampleAt = 0;
   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   sarseq_core uut (.clk(clk), .rst_n(rst_n), .hsoCmd(hsoCmd), .timerInc(timerInc), .swGo(swGo),
      .channelSel(channelSel), .compAbove(compAbove), .muxSel(muxSel), .sampleOn(sampleOn),
      .autoZero(autoZero), .testLevel(testLevel), .status(status));
   sarseq_analog_model model (.clk(clk), .chanLevel(chanLevel), .muxSel(muxSel), .sampleOn(sampleOn),
      .autoZero(autoZero), .testLevel(testLevel), .compAbove(compAbove));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if ($rose(status.busy)) begin
         busyAt <= cyc;
         check(status.done === 1'b0 && testLevel === SAR_RESET, "start state");
         check(expQ.size() > 0 && muxSel === expQ[0][12:10], "channel");
      end
      if ($rose(sampleOn)) begin
         sampleAt <= cyc;
         check(cyc - busyAt == DELAY_STATES * STATE_CYC, "sample delay");
      end
      if (rst_n && $fell(sampleOn)) begin
         check(cyc - sampleAt == SAMPLE_STATES * STATE_CYC && autoZero === 1'b1, "window");
      end
      if (rst_n && $fell(autoZero)) begin
         check(testLevel === SAR_FIRST, "first trial");
      end
      if ($rose(status.done)) begin
         check(cyc - busyAt == CONV_CYC && (cyc - busyAt) * CLK_PERIOD_NS <= CONV_TIME_NS, "time");
         check(expQ.size() > 0 && status.result === expQ[0][9:0], "result");
         if (expQ.size() > 0) begin
            void'(expQ.pop_front());
         end
      end
   end
   task automatic convert(input logic [2:0] ch, input logic [9:0] v, input logic viaCmd);
      int waited;
      chanLevel[ch] <= v;
      channelSel <= ch;
      expQ.push_back({ch, v});
      if (viaCmd) begin
         hsoCmd <= '{valid: 1'b1, code: HSO_START_CODE};
         @(posedge clk);
         hsoCmd <= '0;
         repeat (20) @(posedge clk);
         check(status.busy === 1'b0, "command held for timer");
         timerInc <= 1'b1;
      end else begin
         swGo <= 1'b1;
      end
      @(posedge clk);
      timerInc <= 1'b0;
      swGo <= 1'b0;
      waited = 0;
      do begin
         @(posedge clk);
         waited++;
      end while (status.busy !== 1'b1 && waited < SW_START_STATES * STATE_CYC);
      check(viaCmd ? waited == 1 : waited <= SW_START_STATES * STATE_CYC, "start latency");
      repeat (300) @(posedge clk);
      swGo <= 1'b1;
      chanLevel[ch] <= ~v;
      @(posedge clk);
      swGo <= 1'b0;
      do begin
         @(posedge clk);
         waited++;
      end while (status.busy === 1'b1 && waited < CONV_CYC + 8);
      if (waited >= CONV_CYC + 8) begin
         check(1'b0, "timeout");
         test_done();
      end
      $display("Conversion on channel %0d finished", ch);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         lfsrQ = lfsr_next(lfsrQ);
         convert(3'(i), i < 4 ? EDGE_LEVELS[i[1:0]] : lfsrQ[9:0], i[0]);
      end
      hsoCmd <= '{valid: 1'b1, code: 4'hE};
      @(posedge clk);
      hsoCmd <= '0;
      timerInc <= 1'b1;
      @(posedge clk);
      timerInc <= 1'b0;
      repeat (5) @(posedge clk);
      check(status.busy === 1'b0, "other command code");
      $display("Other command code test finished");
      test_done();
   end
endmodule
`default_nettype wire
